// *** logic/dtc_pkg.sv ***
// dtc_pkg: register map, field positions and reset values of the timer pair
// assumes an aligned 32-bit register bus with one register per word
package dtc_pkg;
    // register byte offsets
    localparam logic [7:0] DTC_OFF_CTRL = 8'h00;
    localparam logic [7:0] DTC_OFF_MODE = 8'h04;
    localparam logic [7:0] DTC_OFF_CLK = 8'h08;
    localparam logic [7:0] DTC_OFF_CNT0 = 8'h0C;
    localparam logic [7:0] DTC_OFF_CNT1 = 8'h10;
    localparam logic [7:0] DTC_OFF_IEN = 8'h14;
    // timer_control_status bits
    localparam int DTC_B_OVF1 = 7;
    localparam int DTC_B_RUN1 = 6;
    localparam int DTC_B_OVF0 = 5;
    localparam int DTC_B_RUN0 = 4;
    // timer_mode_register bits
    localparam int DTC_B_GATE_ENABLE_ONE = 7;
    localparam int DTC_B_CSEL1 = 6;
    localparam int DTC_B_MODE1 = 4;
    localparam int DTC_B_GATE_ENABLE_ZERO = 3;
    localparam int DTC_B_CSEL0 = 2;
    localparam int DTC_B_MODE0 = 0;
    // clock_scale_register bits
    localparam int DTC_B_SYS1 = 4;
    localparam int DTC_B_SYS0 = 3;
    localparam int DTC_B_SCALE = 0;
    // interrupt enable bits
    localparam int DTC_B_IEN0 = 0;
    localparam int DTC_B_IEN1 = 1;
    // reset values
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;
    localparam logic [15:0] DTC_RST_CNT = 16'h0000;
    // mode codes
    localparam logic [1:0] DTC_M13 = 2'b00;
    localparam logic [1:0] DTC_M16 = 2'b01;
    localparam logic [1:0] DTC_M8R = 2'b10;
    localparam logic [1:0] DTC_MSPL = 2'b11;
    // prescale dividers for field codes 0..3
    localparam int DTC_DIV0 = 12;
    localparam int DTC_DIV1 = 4;
    localparam int DTC_DIV2 = 48;
    localparam int DTC_DIV3 = 8;
    // axi responses
    localparam logic [1:0] DTC_OKAY = 2'b00;
    localparam logic [1:0] DTC_SLVERR = 2'b10;
    typedef enum logic [1:0] {DTC_IDLE, DTC_RESP} dtc_wr_e;
endpackage

// *** logic/dtc_timer_pair.sv ***
// dtc_timer_pair: two 8051-style counter/timers behind an AXI4-Lite slave
// assumes event and gate pins synchronous to i_mclk; one clock domain
// Operation
// - counter-select set: timer 0 counts falling edges on its event pin.
// - otherwise timer 0 counts system clock, or prescaled clock if not selected.
// - timer 0 counts only when run and (gate disabled or gate input high).
// - setting run never clears or reloads the count.
// - timer 1 mirrors timer 0 with its own bits and gate input.
// - 16-bit mode uses all sixteen count bits.
// - 8-bit reload: low byte wraps, sets flag, reloads from high byte.
// - a set flag with its interrupt enabled raises an interrupt request.
// - split mode: timer 0 low byte is its own 8-bit counter/timer.
// - split mode: high byte counts internal clock under run one, sets flag one.
// - split mode: timer 1 ignores events, never sets flag, still pulses out.
// - split mode: timer 1 runs in modes 0 to 2, stops in mode 3.
// - 13-bit mode: high byte plus low five bits; wrap 0x1FFF sets flag.
// - mode field 00 13-bit, 01 16-bit, 10 auto-reload, 11 split/inactive.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dtc_timer_pair import dtc_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // pins
    input wire logic i_event_pin_zero,
    input wire logic i_event_pin_one,
    input wire logic i_gate_input_zero,
    input wire logic i_gate_input_one,
    // processor side
    input wire logic i_vector_zero,
    input wire logic i_vector_one,
    output logic o_irq_zero,
    output logic o_irq_one,
    output logic o_ovf_pulse_one
);
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_check
        $error("ADDR_W must be 5 to 8");
    end

    logic [7:0] tcs_q, tmr_q, cks_q, ien_q;
    logic [15:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d;
    logic [5:0] pre_q;
    logic ev0_q, ev1_q;
    logic bv_q, rv_q;
    logic [1:0] br_q, rr_q;
    logic [31:0] rd_q;

    // prescaler tick
    logic [5:0] div_lim;
    logic pre_tick;
    assign div_lim = (cks_q[1:0] == 2'd0) ? 6'(DTC_DIV0 - 1) :
                     (cks_q[1:0] == 2'd1) ? 6'(DTC_DIV1 - 1) :
                     (cks_q[1:0] == 2'd2) ? 6'(DTC_DIV2 - 1) :
                     6'(DTC_DIV3 - 1);
    assign pre_tick = (pre_q >= div_lim);

    // event edges (pins already synchronous)
    wire fall0 = ev0_q & ~i_event_pin_zero;
    wire fall1 = ev1_q & ~i_event_pin_one;

    wire [1:0] m0 = tmr_q[DTC_B_MODE0 +: 2];
    wire [1:0] m1 = tmr_q[DTC_B_MODE1 +: 2];
    wire split = (m0 == DTC_MSPL);
    wire int_tick0 = cks_q[DTC_B_SYS0] | pre_tick;
    wire int_tick1 = cks_q[DTC_B_SYS1] | pre_tick;
    wire tick0 = tmr_q[DTC_B_CSEL0] ? fall0 : int_tick0;
    // in split mode timer 1 counts internal clock only
    wire tick1 = (tmr_q[DTC_B_CSEL1] && !split) ? fall1 : int_tick1;
    wire en0 = tcs_q[DTC_B_RUN0] &
        (~tmr_q[DTC_B_GATE_ENABLE_ZERO] | i_gate_input_zero);
    wire en1_norm = tcs_q[DTC_B_RUN1] &
        (~tmr_q[DTC_B_GATE_ENABLE_ONE] | i_gate_input_one);
    // with timer 0 split, timer 1 runs on its mode field alone
    wire en1 = split ? (m1 != DTC_MSPL) : (en1_norm & (m1 != DTC_MSPL));
    wire inc0 = en0 & tick0;
    wire inc1 = en1 & tick1;
    wire inc_hi0 = split & tcs_q[DTC_B_RUN1] & int_tick0;

    // counter next state, timer 0
    logic ovf0, ovf_hi0, ovf1;
    always_comb begin
        cnt0_d = cnt0_q;
        ovf0 = 1'b0;
        ovf_hi0 = 1'b0;
        unique case (m0)
            DTC_M13: if (inc0) begin
                ovf0 = (cnt0_q[15:8] == 8'hFF) && (cnt0_q[4:0] == 5'h1F);
                if (cnt0_q[4:0] == 5'h1F) begin
                    cnt0_d[4:0] = 5'h00;
                    cnt0_d[15:8] = cnt0_q[15:8] + 8'h01;
                end else begin
                    cnt0_d[4:0] = cnt0_q[4:0] + 5'h01;
                end
            end
            DTC_M16: if (inc0) begin
                ovf0 = (cnt0_q == 16'hFFFF);
                cnt0_d = cnt0_q + 16'h0001;
            end
            DTC_M8R: if (inc0) begin
                ovf0 = (cnt0_q[7:0] == 8'hFF);
                cnt0_d[7:0] = ovf0 ? cnt0_q[15:8] : cnt0_q[7:0] + 8'h01;
            end
            DTC_MSPL: begin
                if (inc0) begin
                    ovf0 = (cnt0_q[7:0] == 8'hFF);
                    cnt0_d[7:0] = cnt0_q[7:0] + 8'h01;
                end
                if (inc_hi0) begin
                    ovf_hi0 = (cnt0_q[15:8] == 8'hFF);
                    cnt0_d[15:8] = cnt0_q[15:8] + 8'h01;
                end
            end
        endcase
    end

    // counter next state, timer 1
    always_comb begin
        cnt1_d = cnt1_q;
        ovf1 = 1'b0;
        unique case (m1)
            DTC_M13: if (inc1) begin
                ovf1 = (cnt1_q[15:8] == 8'hFF) && (cnt1_q[4:0] == 5'h1F);
                if (cnt1_q[4:0] == 5'h1F) begin
                    cnt1_d[4:0] = 5'h00;
                    cnt1_d[15:8] = cnt1_q[15:8] + 8'h01;
                end else begin
                    cnt1_d[4:0] = cnt1_q[4:0] + 5'h01;
                end
            end
            DTC_M16: if (inc1) begin
                ovf1 = (cnt1_q == 16'hFFFF);
                cnt1_d = cnt1_q + 16'h0001;
            end
            DTC_M8R: if (inc1) begin
                ovf1 = (cnt1_q[7:0] == 8'hFF);
                cnt1_d[7:0] = ovf1 ? cnt1_q[15:8] : cnt1_q[7:0] + 8'h01;
            end
            DTC_MSPL: begin
            end
        endcase
    end

    wire set_f0 = ovf0;
    wire set_f1 = split ? ovf_hi0 : ovf1;

    // bus decode
    wire wr_go = i_awvalid & i_wvalid & ~bv_q;
    wire rd_go = i_arvalid & ~rv_q;
    wire [7:0] wa = 8'(i_awaddr);
    wire [7:0] ra = 8'(i_araddr);
    wire wb0 = wr_go & i_wstrb[0];
    wire wb1 = wr_go & i_wstrb[1];
    wire w_ctrl = wb0 & (wa == DTC_OFF_CTRL);
    wire w_mode = wb0 & (wa == DTC_OFF_MODE);
    wire w_clk = wb0 & (wa == DTC_OFF_CLK);
    wire w_ien = wb0 & (wa == DTC_OFF_IEN);
    wire w_c0l = wb0 & (wa == DTC_OFF_CNT0);
    wire w_c0h = wb1 & (wa == DTC_OFF_CNT0);
    wire w_c1l = wb0 & (wa == DTC_OFF_CNT1);
    wire w_c1h = wb1 & (wa == DTC_OFF_CNT1);
    wire wa_ok = (wa == DTC_OFF_CTRL) | (wa == DTC_OFF_MODE) |
        (wa == DTC_OFF_CLK) | (wa == DTC_OFF_CNT0) |
        (wa == DTC_OFF_CNT1) | (wa == DTC_OFF_IEN);
    wire ra_ok = (ra == DTC_OFF_CTRL) | (ra == DTC_OFF_MODE) |
        (ra == DTC_OFF_CLK) | (ra == DTC_OFF_CNT0) |
        (ra == DTC_OFF_CNT1) | (ra == DTC_OFF_IEN);
    wire [31:0] rmux = (ra == DTC_OFF_CTRL) ? {24'h0000_00, tcs_q} :
        (ra == DTC_OFF_MODE) ? {24'h0000_00, tmr_q} :
        (ra == DTC_OFF_CLK) ? {24'h0000_00, cks_q} :
        (ra == DTC_OFF_CNT0) ? {16'h0000, cnt0_q} :
        (ra == DTC_OFF_CNT1) ? {16'h0000, cnt1_q} :
        (ra == DTC_OFF_IEN) ? {24'h0000_00, ien_q} : 32'h0000_0000;

    // flags: hardware set wins over vector or software clear
    logic [7:0] tcs_d;
    always_comb begin
        tcs_d = w_ctrl ? i_wdata[7:0] : tcs_q;
        if (w_ctrl && !i_wdata[DTC_B_OVF0]) begin
            tcs_d[DTC_B_OVF0] = 1'b0;
        end else if (!w_ctrl) begin
            tcs_d[DTC_B_OVF0] = tcs_q[DTC_B_OVF0] & ~i_vector_zero;
        end
        if (w_ctrl && !i_wdata[DTC_B_OVF1]) begin
            tcs_d[DTC_B_OVF1] = 1'b0;
        end else if (!w_ctrl) begin
            tcs_d[DTC_B_OVF1] = tcs_q[DTC_B_OVF1] & ~i_vector_one;
        end
        if (set_f0) begin
            tcs_d[DTC_B_OVF0] = 1'b1;
        end
        if (set_f1) begin
            tcs_d[DTC_B_OVF1] = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tcs_q <= DTC_RST_BYTE;
            tmr_q <= DTC_RST_BYTE;
            cks_q <= DTC_RST_BYTE;
            ien_q <= DTC_RST_BYTE;
            pre_q <= 6'h00;
            ev0_q <= 1'b1;
            ev1_q <= 1'b1;
        end else begin
            tcs_q <= tcs_d;
            if (w_mode) tmr_q <= i_wdata[7:0];
            if (w_clk) cks_q <= i_wdata[7:0];
            if (w_ien) ien_q <= i_wdata[7:0];
            pre_q <= pre_tick ? 6'h00 : pre_q + 6'h01;
            ev0_q <= i_event_pin_zero;
            ev1_q <= i_event_pin_one;
        end
    end

    // counts: software write overrides a same-cycle increment
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt0_q <= DTC_RST_CNT;
            cnt1_q <= DTC_RST_CNT;
        end else begin
            cnt0_q[7:0] <= w_c0l ? i_wdata[7:0] : cnt0_d[7:0];
            cnt0_q[15:8] <= w_c0h ? i_wdata[15:8] : cnt0_d[15:8];
            cnt1_q[7:0] <= w_c1l ? i_wdata[7:0] : cnt1_d[7:0];
            cnt1_q[15:8] <= w_c1h ? i_wdata[15:8] : cnt1_d[15:8];
        end
    end

    // bus responses
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bv_q <= 1'b0;
            br_q <= DTC_OKAY;
            rv_q <= 1'b0;
            rr_q <= DTC_OKAY;
            rd_q <= 32'h0000_0000;
            o_ovf_pulse_one <= 1'b0;
        end else begin
            if (wr_go) begin
                bv_q <= 1'b1;
                br_q <= wa_ok ? DTC_OKAY : DTC_SLVERR;
            end else if (i_bready) begin
                bv_q <= 1'b0;
            end
            if (rd_go) begin
                rv_q <= 1'b1;
                rr_q <= ra_ok ? DTC_OKAY : DTC_SLVERR;
                rd_q <= rmux;
            end else if (i_rready) begin
                rv_q <= 1'b0;
            end
            o_ovf_pulse_one <= ovf1;
        end
    end

    assign o_awready = wr_go;
    assign o_wready = wr_go;
    assign o_bvalid = bv_q;
    assign o_bresp = br_q;
    assign o_arready = rd_go;
    assign o_rvalid = rv_q;
    assign o_rresp = rr_q;
    assign o_rdata = rd_q;
    assign o_irq_zero = tcs_q[DTC_B_OVF0] & ien_q[DTC_B_IEN0];
    assign o_irq_one = tcs_q[DTC_B_OVF1] & ien_q[DTC_B_IEN1];

    // checks
    a_gate_halts: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!en0 && m0 == DTC_M16 && !w_c0l && !w_c0h)
        |=> cnt0_q == $past(cnt0_q))
        else $error("timer 0 moved while disabled");
    a_run_keeps: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        ($rose(tcs_q[DTC_B_RUN0]) && m0 == DTC_M16)
        |-> cnt0_q == $past(cnt0_q) || cnt0_q == $past(cnt0_q) + 16'h1)
        else $error("run set altered count");
    a_reload_value: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (m0 == DTC_M8R && inc0 && cnt0_q[7:0] == 8'hFF && !w_c0l && !w_c0h)
        |=> cnt0_q[7:0] == $past(cnt0_q[15:8]) && tcs_q[DTC_B_OVF0])
        else $error("auto-reload wrong");
    a_wrap_13: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (m0 == DTC_M13 && inc0 && cnt0_q[15:8] == 8'hFF &&
         cnt0_q[4:0] == 5'h1F) |=> tcs_q[DTC_B_OVF0])
        else $error("13-bit wrap lost flag");
    a_event_count: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (m0 == DTC_M16 && tmr_q[DTC_B_CSEL0] && en0 && fall0 &&
         cnt0_q != 16'hFFFF && !w_c0l && !w_c0h)
        |=> cnt0_q == $past(cnt0_q) + 16'h1)
        else $error("event edge not counted");
    a_split_nof1: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (split && !inc_hi0 && ovf1) |=> $stable(tcs_q[DTC_B_OVF1])
        || !tcs_q[DTC_B_OVF1])
        else $error("timer 1 set flag in split mode");
    a_split_hi: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (split && tcs_q[DTC_B_RUN1] && cks_q[DTC_B_SYS0] && !w_c0h)
        |=> cnt0_q[15:8] == 8'($past(cnt0_q[15:8]) + 8'h1))
        else $error("split high byte not counting");
    a_split_pulse: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (split && ovf1) |=> o_ovf_pulse_one)
        else $error("timer 1 overflow pulse lost in split mode");
    a_irq_follow: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (set_f0 && ien_q[DTC_B_IEN0] && !w_ien) |=> o_irq_zero)
        else $error("no interrupt on overflow");
    a_irq_one: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (set_f1 && ien_q[DTC_B_IEN1] && !w_ien) |=> o_irq_one)
        else $error("no timer 1 interrupt on overflow");
    a_vec_clear: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_vector_zero && !set_f0 && !w_ctrl) |=> !tcs_q[DTC_B_OVF0])
        else $error("vector did not clear timer 0 flag");
    a_t1_gate: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (m1 == DTC_M16 && !split && tmr_q[DTC_B_GATE_ENABLE_ONE] &&
         !i_gate_input_one && !w_c1l && !w_c1h) |=> $stable(cnt1_q))
        else $error("timer 1 moved with gate low");
    a_t1_stop: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (m1 == DTC_MSPL && !w_c1l && !w_c1h) |=> $stable(cnt1_q))
        else $error("timer 1 ran in mode 3");
    c_ovf16: cover property (@(posedge i_mclk) m0 == DTC_M16 && ovf0);
    c_reload: cover property (@(posedge i_mclk) m1 == DTC_M8R && ovf1);
    c_split: cover property (@(posedge i_mclk) split && ovf_hi0);
    c_gate: cover property (@(posedge i_mclk) tmr_q[DTC_B_GATE_ENABLE_ZERO] && inc0);
    c_split_t1: cover property (@(posedge i_mclk) split && ovf1);
endmodule // dtc_timer_pair

// *** bench/dtc_pin_model.sv ***
// dtc_pin_model: far-side source of the event and gate pins
// assumes its tasks are called just after a rising edge of i_mclk
`timescale 1ns/1ps
module dtc_pin_model (
    // clock
    input wire logic i_mclk,
    // pins
    output logic o_event_pin_zero,
    output logic o_event_pin_one,
    output logic o_gate_input_zero,
    output logic o_gate_input_one
);
    initial begin
        o_event_pin_zero = 1'b1;
        o_event_pin_one = 1'b1;
        o_gate_input_zero = 1'b0;
        o_gate_input_one = 1'b0;
    end
    // n falling edges; each level stands hold clocks, two at least
    task automatic falls(input bit t1, input int n, input int hold);
        for (int i = 0; i < 2 * n; i++) begin
            if (t1) begin
                o_event_pin_one <= i[0];
            end else begin
                o_event_pin_zero <= i[0];
            end
            repeat (hold) @(posedge i_mclk);
        end
    endtask
    task automatic gate(input bit t1, input logic lvl);
        if (t1) begin
            o_gate_input_one <= lvl;
        end else begin
            o_gate_input_zero <= lvl;
        end
    endtask
endmodule // dtc_pin_model

// *** bench/testbench.sv ***
// testbench: register-level tests of the timer pair
// assumes dtc_pin_model drives the event and gate pins
`timescale 1ns/1ps
module testbench;
    logic i_mclk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid;
    logic i_rready, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, rsp;
    logic i_event_pin_zero, i_event_pin_one, i_gate_input_zero;
    logic i_gate_input_one, i_vector_zero, i_vector_one;
    logic o_irq_zero, o_irq_one, o_ovf_pulse_one;
    int n_fail = 0;
    int checked = 0;
    int n_pulse = 0;
    int p;
    dtc_timer_pair dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready),
        .i_event_pin_zero(i_event_pin_zero),
        .i_event_pin_one(i_event_pin_one),
        .i_gate_input_zero(i_gate_input_zero),
        .i_gate_input_one(i_gate_input_one),
        .i_vector_zero(i_vector_zero), .i_vector_one(i_vector_one),
        .o_irq_zero(o_irq_zero), .o_irq_one(o_irq_one),
        .o_ovf_pulse_one(o_ovf_pulse_one));
    dtc_pin_model pins (.i_mclk(i_mclk),
        .o_event_pin_zero(i_event_pin_zero),
        .o_event_pin_one(i_event_pin_one),
        .o_gate_input_zero(i_gate_input_zero),
        .o_gate_input_one(i_gate_input_one));
    // counts timer 1 overflow pulses
    always @(posedge i_mclk) begin
        if (o_ovf_pulse_one === 1'b1) n_pulse++;
    end
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic w(input logic [7:0] a, input logic [15:0] v);
        bit aw = 1'b1;
        bit wd = 1'b1;
        i_awaddr <= a;
        i_wdata <= {16'h0000, v};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        while (aw || wd) begin
            @(posedge i_mclk);
            aw = aw && !o_awready;
            wd = wd && !o_wready;
            i_awvalid <= aw;
            i_wvalid <= wd;
            i_bready <= !(aw || wd);
        end
        do @(posedge i_mclk); while (!o_bvalid);
        i_bready <= 1'b0;
        chk({30'h0, o_bresp}, 32'h0000_0000);
    endtask
    task automatic rd(input logic [7:0] a);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do @(posedge i_mclk); while (!o_arready);
        i_arvalid <= 1'b0;
        i_rready <= 1'b1;
        do @(posedge i_mclk); while (!o_rvalid);
        d = o_rdata;
        rsp = o_rresp;
        i_rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        chk({30'h0, rsp}, 32'h0000_0000);
        chk(d, {16'h0000, e});
    endtask
    // one-cycle vector pulse to timer 0 or timer 1
    task automatic vec(input bit t1);
        i_vector_zero <= !t1;
        i_vector_one <= t1;
        @(posedge i_mclk);
        {i_vector_zero, i_vector_one} <= 2'b00;
        @(posedge i_mclk);
    endtask
    initial begin
        {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        {i_vector_zero, i_vector_one, i_awaddr, i_araddr} = '0;
        i_wdata = 32'h0000_0000;
        i_wstrb = 4'hF;
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        for (int a = 0; a < 24; a += 4) begin
            rc(8'(a), 16'h0000);
        end
        rd(8'h18);
        chk({30'h0, rsp}, 32'h0000_0002);
        // 16-bit event counting through the wrap
        w(8'h14, 16'h0003);
        w(8'h04, 16'h0005);
        w(8'h0C, 16'hFFFE);
        w(8'h00, 16'h0010);
        pins.falls(1'b0, 3, 2);
        rc(8'h0C, 16'h0001);
        rc(8'h00, 16'h0030);
        chk({31'h0, o_irq_zero}, 32'h0000_0001);
        vec(1'b0);
        chk({31'h0, o_irq_zero}, 32'h0000_0000);
        // gated counting, then run toggled
        w(8'h04, 16'h000D);
        pins.falls(1'b0, 2, 3);
        rc(8'h0C, 16'h0001);
        pins.gate(1'b0, 1'b1);
        pins.falls(1'b0, 2, 2);
        rc(8'h0C, 16'h0003);
        w(8'h00, 16'h0000);
        w(8'h00, 16'h0010);
        rc(8'h0C, 16'h0003);
        // 13-bit wrap
        w(8'h04, 16'h0004);
        w(8'h0C, 16'hFF1F);
        pins.falls(1'b0, 1, 2);
        rd(8'h0C);
        chk(d & 32'h0000_FF1F, 32'h0000_0000);
        rc(8'h00, 16'h0030);
        w(8'h00, 16'h0010);
        rc(8'h00, 16'h0010);
        // 8-bit auto-reload
        w(8'h04, 16'h0006);
        w(8'h0C, 16'h80FF);
        pins.falls(1'b0, 3, 2);
        rc(8'h0C, 16'h8082);
        rc(8'h00, 16'h0030);
        // timer 1 on its own pins and bits
        w(8'h04, 16'h0050);
        w(8'h10, 16'hFFFF);
        w(8'h00, 16'h0040);
        pins.falls(1'b1, 1, 2);
        rc(8'h10, 16'h0000);
        rc(8'h00, 16'h00C0);
        chk({31'h0, o_irq_one}, 32'h0000_0001);
        vec(1'b1);
        chk({31'h0, o_irq_one}, 32'h0000_0000);
        w(8'h04, 16'h00D0);
        pins.falls(1'b1, 2, 2);
        rc(8'h10, 16'h0000);
        // split mode
        w(8'h00, 16'h0000);
        w(8'h04, 16'h0037);
        w(8'h08, 16'h0008);
        w(8'h0C, 16'h00FE);
        w(8'h10, 16'h1234);
        w(8'h00, 16'h0010);
        pins.falls(1'b0, 2, 2);
        rc(8'h0C, 16'h0000);
        rc(8'h00, 16'h0030);
        rc(8'h10, 16'h1234);
        w(8'h00, 16'h0040);
        repeat (300) @(posedge i_mclk);
        rd(8'h00);
        chk(d & 32'h0000_0080, 32'h0000_0080);
        rd(8'h0C);
        chk(d & 32'h0000_00FF, 32'h0000_0000);
        w(8'h04, 16'h0017);
        repeat (60) @(posedge i_mclk);
        rd(8'h10);
        chk({31'h0, d !== 32'h0000_1234}, 32'h0000_0001);
        // timer 1 wraps in split mode: pulse out, flag left clear
        w(8'h00, 16'h0000);
        p = n_pulse;
        w(8'h10, 16'hFFFF);
        repeat (40) @(posedge i_mclk);
        chk(n_pulse - p, 32'h0000_0001);
        rc(8'h00, 16'h0000);
        // system clock against the slowest prescale
        w(8'h04, 16'h0001);
        w(8'h0C, 16'h0000);
        w(8'h00, 16'h0010);
        repeat (40) @(posedge i_mclk);
        w(8'h00, 16'h0000);
        rd(8'h0C);
        chk({31'h0, d >= 32'h0000_0028}, 32'h0000_0001);
        w(8'h08, 16'h0002);
        w(8'h0C, 16'h0000);
        w(8'h00, 16'h0010);
        repeat (40) @(posedge i_mclk);
        w(8'h00, 16'h0000);
        rd(8'h0C);
        chk({31'h0, d < 32'h0000_0004}, 32'h0000_0001);
        results();
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        chk(32'h0000_0001, 32'h0000_0000);
        results();
    end
endmodule // testbench
